// ---- src/timer16_pkg.sv ----
`default_nettype none
package timer16_pkg;

  // byte addresses on the register port
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h0;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
  localparam logic [3:0] ADDR_CAPTURE_LOW = 4'h2;
  localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h3;
  localparam logic [3:0] ADDR_CMPA_LOW = 4'h4;
  localparam logic [3:0] ADDR_CMPA_HIGH = 4'h5;
  localparam logic [3:0] ADDR_CMPB_LOW = 4'h6;
  localparam logic [3:0] ADDR_CMPB_HIGH = 4'h7;
  localparam logic [3:0] ADDR_CTRL_A = 4'h8;
  localparam logic [3:0] ADDR_CTRL_B = 4'h9;
  localparam logic [3:0] ADDR_CMP_CTRL = 4'ha;
  localparam logic [3:0] ADDR_FLAGS = 4'hb;
  localparam logic [3:0] ADDR_MASK = 4'hc;

  // field positions
  localparam int CTRLB_FILTER_BIT = 7;
  localparam int CTRLB_EDGE_BIT = 6;
  localparam int CMPCTRL_SELECT_BIT = 2;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CAP_BIT = 1;

  // reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // counter limits and fixed tops
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  // prescaler tap masks, in system clock cycles minus one
  localparam logic [9:0] PRESC_DIV8 = 10'h007;
  localparam logic [9:0] PRESC_DIV64 = 10'h03f;
  localparam logic [9:0] PRESC_DIV256 = 10'h0ff;
  localparam logic [9:0] PRESC_DIV1024 = 10'h3ff;

  // clock source select codes
  localparam logic [2:0] CSS_STOP = 3'h0;
  localparam logic [2:0] CSS_DIV1 = 3'h1;
  localparam logic [2:0] CSS_DIV8 = 3'h2;
  localparam logic [2:0] CSS_DIV64 = 3'h3;
  localparam logic [2:0] CSS_DIV256 = 3'h4;
  localparam logic [2:0] CSS_DIV1024 = 3'h5;
  localparam logic [2:0] CSS_EXT_FALL = 3'h6;
  localparam logic [2:0] CSS_EXT_RISE = 3'h7;

  // noise filter window length
  localparam int FILTER_SAMPLES = 4;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } bus_req_t;

  // complete block state
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] capture;
    logic [15:0] cmpA;
    logic [15:0] cmpB;
    logic [7:0] tempHigh;
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic [7:0] cmpCtrl;
    logic [7:0] mask;
    logic capFlag;
    logic ovfFlag;
    logic countDown;
    logic [9:0] presc;
    logic extNow;
    logic extPrev;
    logic inSample;
    logic [FILTER_SAMPLES-1:0] window;
    logic filtered;
    logic [7:0] rdData;
    logic captureIrq;
    logic overflowIrq;
    logic atTop;
    logic atBottom;
  } state_t;

endpackage : timer16_pkg
`default_nettype wire

// ---- src/timer16_counter_capture.sv ----
// Behaviour
// - high byte location reaches shared latch
// - low read latches high; low write loads
// - 16-bit up/down counter, top and bottom
// - clock source select zero stops counting
// - counter accessible with or without ticks
// - cpu write beats count or clear
// - mode select steers clear, up, down
// - overflow flag per mode, interrupt capable
// - selected edge copies counter to capture
// - capture flag set with the copy
// - enabled flag interrupts, cleared on ack
// - writing one clears capture flag
// - capture low read latches its high
// - capture writable only in capture-top modes
// - select bit picks comparator as source
// - filter changes only on four equal
// - filter adds four cycles of delay
// - filter runs on system clock
// - capture input off in capture-top modes
// - capture input sampled like count pin
// - shared latch holds between accesses
// - one latch for all 16-bit registers
// - compare reads bypass the shared latch
`default_nettype none
module timer16_counter_capture
  import timer16_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire bus_req_t busReq,
  output logic [7:0] rdData,
  // pins and comparator
  input wire logic captureInputPin,
  input wire logic comparatorOutput,
  input wire logic externalCountPin,
  // interrupt acknowledges
  input wire logic captureAck,
  input wire logic overflowAck,
  // interrupt requests
  output logic captureIrq,
  output logic overflowIrq,
  // to waveform logic
  output logic atTop,
  output logic atBottom,
  output logic [3:0] waveformModeSelect
);

  state_t q; // registered state
  state_t d; // next state

  // decoded controls
  logic [3:0] mode;
  logic [2:0] clockSourceSelect;
  logic captureFilterEnable;
  logic captureEdgePolarity;
  logic comparatorCaptureSelect;
  logic captureTopMode;
  logic dualSlope;
  logic ctcMode;
  logic [15:0] topValue;
  logic timerTick;
  logic rawInput;
  logic filtNext;
  logic captureTrig;
  logic [15:0] countNext;
  logic ovfSet;
  logic wrHit;
  logic rdHit;

  // control field decode
  always_comb begin
    mode = {q.ctrlB[4:3], q.ctrlA[1:0]};
    clockSourceSelect = q.ctrlB[2:0];
    captureFilterEnable = q.ctrlB[CTRLB_FILTER_BIT];
    captureEdgePolarity = q.ctrlB[CTRLB_EDGE_BIT];
    comparatorCaptureSelect = q.cmpCtrl[CMPCTRL_SELECT_BIT];
    captureTopMode = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'hc) || (mode == 4'he);
    dualSlope = (mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
    ctcMode = (mode == 4'h4) || (mode == 4'hc);
  end

  // top value per mode
  always_comb begin
    case (mode)
      4'h1, 4'h5: topValue = TOP_8BIT;
      4'h2, 4'h6: topValue = TOP_9BIT;
      4'h3, 4'h7: topValue = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: topValue = q.cmpA;
      4'h8, 4'ha, 4'hc, 4'he: topValue = q.capture;
      default: topValue = COUNT_MAX;
    endcase
  end

  // timer tick from prescaler taps or external pin
  always_comb begin
    case (clockSourceSelect)
      CSS_STOP: timerTick = 1'b0;
      CSS_DIV1: timerTick = 1'b1;
      CSS_DIV8: timerTick = (q.presc[2:0] == PRESC_DIV8[2:0]);
      CSS_DIV64: timerTick = (q.presc[5:0] == PRESC_DIV64[5:0]);
      CSS_DIV256: timerTick = (q.presc[7:0] == PRESC_DIV256[7:0]);
      CSS_DIV1024: timerTick = (q.presc == PRESC_DIV1024);
      CSS_EXT_FALL: timerTick = q.extPrev && !q.extNow;
      CSS_EXT_RISE: timerTick = !q.extPrev && q.extNow;
      default: timerTick = 1'b0;
    endcase
  end

  // the filter window keeps shifting in capture-top modes, so
  // leaving such a mode cannot replay a stale edge
  // capture source, filter and edge detector
  always_comb begin
    rawInput = comparatorCaptureSelect ? comparatorOutput : captureInputPin;
    filtNext = q.filtered;
    if (!captureFilterEnable) begin
      filtNext = q.inSample;
    end else if ((q.window == {FILTER_SAMPLES{1'b1}}) || (q.window == '0)) begin
      filtNext = q.window[0];
    end
    captureTrig = !captureTopMode && (filtNext != q.filtered)
                  && (filtNext == captureEdgePolarity);
  end

  // counting sequence for one tick
  always_comb begin
    countNext = q.count;
    ovfSet = 1'b0;
    if (dualSlope) begin
      if (q.countDown) begin
        if (q.count == COUNT_ZERO) begin
          countNext = q.count + 16'h0001;
          ovfSet = 1'b1;
        end else begin
          countNext = q.count - 16'h0001;
        end
      end else if (q.count >= topValue) begin
        countNext = q.count - 16'h0001;
      end else begin
        countNext = q.count + 16'h0001;
      end
    end else if (q.count >= topValue) begin
      countNext = COUNT_ZERO;
      ovfSet = !ctcMode || (q.count == COUNT_MAX);
    end else begin
      countNext = q.count + 16'h0001;
    end
  end

  // next state
  always_comb begin
    d = q;
    wrHit = busReq.wrStrobe;
    rdHit = busReq.rdStrobe;
    // prescaler held at zero while stopped, else counting; pin samples
    d.presc = (clockSourceSelect == CSS_STOP) ? 10'h000 : q.presc + 10'h001;
    d.extNow = externalCountPin;
    d.extPrev = q.extNow;
    d.inSample = rawInput;
    d.window = {q.window[FILTER_SAMPLES-2:0], q.inSample};
    d.filtered = filtNext;
    // counter step
    if (timerTick) begin
      d.count = countNext;
      if (dualSlope) begin
        if (q.countDown && q.count == COUNT_ZERO) begin
          d.countDown = 1'b0;
        end else if (!q.countDown && q.count >= topValue) begin
          d.countDown = 1'b1;
        end
      end else begin
        d.countDown = 1'b0;
      end
    end
    // capture of the counter
    if (captureTrig) begin
      d.capture = q.count;
    end
    // read path, data one cycle later
    d.rdData = BYTE_RESET;
    if (rdHit) begin
      case (busReq.addr)
        ADDR_COUNT_LOW: begin
          d.rdData = q.count[7:0];
          d.tempHigh = q.count[15:8];
        end
        ADDR_CAPTURE_LOW: begin
          d.rdData = q.capture[7:0];
          d.tempHigh = q.capture[15:8];
        end
        ADDR_COUNT_HIGH, ADDR_CAPTURE_HIGH: d.rdData = q.tempHigh;
        ADDR_CMPA_LOW: d.rdData = q.cmpA[7:0];
        ADDR_CMPA_HIGH: d.rdData = q.cmpA[15:8];
        ADDR_CMPB_LOW: d.rdData = q.cmpB[7:0];
        ADDR_CMPB_HIGH: d.rdData = q.cmpB[15:8];
        ADDR_CTRL_A: d.rdData = q.ctrlA;
        ADDR_CTRL_B: d.rdData = q.ctrlB;
        ADDR_CMP_CTRL: d.rdData = q.cmpCtrl;
        ADDR_FLAGS: d.rdData = {6'h00, q.capFlag, q.ovfFlag};
        ADDR_MASK: d.rdData = q.mask;
        default: d.rdData = BYTE_RESET; // unmapped reads zero
      endcase
    end
    // write path, beats the counter step
    if (wrHit) begin
      case (busReq.addr)
        ADDR_COUNT_HIGH, ADDR_CAPTURE_HIGH, ADDR_CMPA_HIGH, ADDR_CMPB_HIGH: begin
          d.tempHigh = busReq.wrData;
        end
        ADDR_COUNT_LOW: d.count = {q.tempHigh, busReq.wrData};
        ADDR_CAPTURE_LOW: begin
          if (captureTopMode) begin
            d.capture = {q.tempHigh, busReq.wrData};
          end
        end
        ADDR_CMPA_LOW: d.cmpA = {q.tempHigh, busReq.wrData};
        ADDR_CMPB_LOW: d.cmpB = {q.tempHigh, busReq.wrData};
        ADDR_CTRL_A: d.ctrlA = busReq.wrData;
        ADDR_CTRL_B: d.ctrlB = busReq.wrData;
        ADDR_CMP_CTRL: d.cmpCtrl = busReq.wrData;
        ADDR_MASK: d.mask = busReq.wrData;
        default: d.tempHigh = d.tempHigh; // flags handled below
      endcase
    end
    // flags: clear by one-write or ack, set wins
    if ((wrHit && busReq.addr == ADDR_FLAGS && busReq.wrData[FLAG_CAP_BIT]) || captureAck) begin
      d.capFlag = 1'b0;
    end
    if ((wrHit && busReq.addr == ADDR_FLAGS && busReq.wrData[FLAG_OVF_BIT]) || overflowAck) begin
      d.ovfFlag = 1'b0;
    end
    if (captureTrig) begin
      d.capFlag = 1'b1;
    end
    if (timerTick && ovfSet && !(wrHit && busReq.addr == ADDR_COUNT_LOW)) begin
      d.ovfFlag = 1'b1;
    end
    // registered requests and limit markers
    d.captureIrq = q.capFlag && q.mask[FLAG_CAP_BIT];
    d.overflowIrq = q.ovfFlag && q.mask[FLAG_OVF_BIT];
    d.atTop = (d.count == topValue);
    d.atBottom = (d.count == COUNT_ZERO);
  end

  // synchronous reset clears every field, so no output
  // can show a stale request in the first cycle after it
  // state register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rdData = q.rdData;
  assign captureIrq = q.captureIrq;
  assign overflowIrq = q.overflowIrq;
  assign atTop = q.atTop;
  assign atBottom = q.atBottom;
  assign waveformModeSelect = {q.ctrlB[4:3], q.ctrlA[1:0]};

  // high byte write lands in the latch
  AST_HIGH_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    busReq.wrStrobe && busReq.addr == ADDR_COUNT_HIGH |=> q.tempHigh == $past(busReq.wrData))
    else $error("high byte write missed latch");

  // low read copies counter high byte
  AST_LOW_READ: assert property (@(posedge sys_clk) disable iff (reset)
    busReq.rdStrobe && busReq.addr == ADDR_COUNT_LOW
    |=> q.tempHigh == $past(q.count[15:8]) && q.rdData == $past(q.count[7:0]))
    else $error("low read did not latch high byte");

  // low write loads whole counter despite ticks
  AST_WRITE_PRIORITY: assert property (@(posedge sys_clk) disable iff (reset)
    busReq.wrStrobe && busReq.addr == ADDR_COUNT_LOW
    |=> q.count == {$past(q.tempHigh), $past(busReq.wrData)})
    else $error("counter write lost");

  // stopped timer holds still
  AST_STOPPED: assert property (@(posedge sys_clk) disable iff (reset)
    q.ctrlB[2:0] == CSS_STOP && !busReq.wrStrobe |=> $stable(q.count))
    else $error("stopped counter moved");

  // capture copies count and sets flag together
  AST_CAPTURE: assert property (@(posedge sys_clk) disable iff (reset)
    captureTrig |=> q.capture == $past(q.count) && q.capFlag)
    else $error("capture copy or flag wrong");

  // one-write clears the flag when no new event
  AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
    busReq.wrStrobe && busReq.addr == ADDR_FLAGS && busReq.wrData[FLAG_CAP_BIT]
    && !captureTrig |=> !q.capFlag)
    else $error("capture flag not cleared");

  // compare read leaves latch alone
  AST_CMP_READ: assert property (@(posedge sys_clk) disable iff (reset)
    busReq.rdStrobe && busReq.addr == ADDR_CMPA_LOW && !busReq.wrStrobe
    |=> $stable(q.tempHigh))
    else $error("compare read touched latch");

  // filtered level holds unless window agrees
  AST_FILTER: assert property (@(posedge sys_clk) disable iff (reset)
    captureFilterEnable && q.window != '0 && q.window != {FILTER_SAMPLES{1'b1}}
    |=> $stable(q.filtered))
    else $error("filter changed on mixed samples");

  // capture write refused outside capture-top modes
  AST_CAP_WRITE_BLOCK: assert property (@(posedge sys_clk) disable iff (reset)
    busReq.wrStrobe && busReq.addr == ADDR_CAPTURE_LOW && !captureTopMode && !captureTrig
    |=> $stable(q.capture))
    else $error("capture written in wrong mode");

  // enabled flag raises the request next cycle
  AST_IRQ: assert property (@(posedge sys_clk) disable iff (reset)
    q.capFlag && q.mask[FLAG_CAP_BIT] |=> captureIrq)
    else $error("capture request missing");

  // no capture edges in capture-top modes
  AST_INPUT_OFF: assert property (@(posedge sys_clk) disable iff (reset)
    captureTopMode && !busReq.wrStrobe |=> $stable(q.capture))
    else $error("capture in capture-top mode");

  // further checks on latch, counting and capture

  // capture low read copies its high byte
  AST_CAP_LOW_READ: assert property (@(posedge sys_clk) disable iff (reset)
    busReq.rdStrobe && busReq.addr == ADDR_CAPTURE_LOW
    |=> q.tempHigh == $past(q.capture[15:8]) && q.rdData == $past(q.capture[7:0]))
    else $error("capture low read did not latch high byte");

  // count and capture high locations read back the latch
  AST_HIGH_READ: assert property (@(posedge sys_clk) disable iff (reset)
    busReq.rdStrobe && (busReq.addr == ADDR_COUNT_HIGH || busReq.addr == ADDR_CAPTURE_HIGH)
    |=> q.rdData == $past(q.tempHigh))
    else $error("high byte read bypassed latch");

  // latch keeps its value without bus traffic
  AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    !busReq.wrStrobe && !busReq.rdStrobe |=> $stable(q.tempHigh))
    else $error("shared latch drifted");

  // compare low write takes the latch as high byte
  AST_CMPA_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    busReq.wrStrobe && busReq.addr == ADDR_CMPA_LOW
    |=> q.cmpA == {$past(q.tempHigh), $past(busReq.wrData)})
    else $error("compare write ignored latch");

  // plain mode steps up by one each cycle
  AST_COUNT_UP: assert property (@(posedge sys_clk) disable iff (reset)
    clockSourceSelect == CSS_DIV1 && mode == 4'h0 && q.count != COUNT_MAX && !busReq.wrStrobe
    |=> q.count == $past(q.count) + 16'h0001)
    else $error("counter did not step up");

  // plain mode wraps from maximum and raises overflow
  AST_OVF_WRAP: assert property (@(posedge sys_clk) disable iff (reset)
    timerTick && mode == 4'h0 && q.count == COUNT_MAX && !busReq.wrStrobe
    |=> q.ovfFlag && q.count == COUNT_ZERO)
    else $error("wrap without overflow");

  // acknowledge clears the capture flag
  AST_ACK_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
    captureAck && !captureTrig |=> !q.capFlag)
    else $error("acknowledge left capture flag set");

  // unfiltered matching edge captures on the next cycle
  AST_DIRECT_EDGE: assert property (@(posedge sys_clk) disable iff (reset)
    !captureFilterEnable && !captureTopMode && q.inSample != q.filtered
    && q.inSample == captureEdgePolarity |=> q.capFlag && q.capture == $past(q.count))
    else $error("unfiltered edge missed");

endmodule : timer16_counter_capture
`default_nettype wire

// ---- testbench/cpu_bus_model.sv ----
`default_nettype none
module cpu_bus_model
  import timer16_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // register port
  output var bus_req_t busReq,
  input wire logic [7:0] rdData
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus from time zero
  initial begin
    busReq = '0;
  end

  // one write cycle, released data is inverted so it is never reused
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
    @(posedge sys_clk);
    busReq.wrStrobe <= 1'b0;
    busReq.wrData <= ~d;
  endtask : wr

  // one read cycle, data taken at the edge closing the answer cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
    @(posedge sys_clk);
    busReq.rdStrobe <= 1'b0;
    @(posedge sys_clk);
    d = rdData;
  endtask : rd

  // 16-bit write, high byte first
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16

  // 16-bit read, low byte first
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask : rd16
endmodule : cpu_bus_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin failCount++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top
  import timer16_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // design signals
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  bus_req_t busReq;
  logic [7:0] rdData;
  logic captureInputPin = 1'b0;
  logic comparatorOutput = 1'b0;
  logic externalCountPin = 1'b0; // external count pin
  logic captureAck = 1'b0;
  logic overflowAck = 1'b0;
  logic captureIrq, overflowIrq, atTop, atBottom;
  logic [3:0] waveformModeSelect;
  // bench state
  int failCount = 0;
  int checkCount = 0;
  int cycleCount = 0;
  int seed;
  int n;
  logic [15:0] v, w;
  logic [7:0] b;

  // device under test
  timer16_counter_capture i_dut (
    .sys_clk(sys_clk), .reset(reset), .busReq(busReq), .rdData(rdData),
    .captureInputPin(captureInputPin), .comparatorOutput(comparatorOutput),
    .externalCountPin(externalCountPin), .captureAck(captureAck),
    .overflowAck(overflowAck), .captureIrq(captureIrq), .overflowIrq(overflowIrq),
    .atTop(atTop), .atBottom(atBottom), .waveformModeSelect(waveformModeSelect));

  // cpu side of the register port
  cpu_bus_model i_cpu (.sys_clk(sys_clk), .busReq(busReq), .rdData(rdData));

  // 10 mhz clock
  always #50 sys_clk = ~sys_clk;

  // verdict and end of run
  task automatic finalReport();
    if (failCount == 0 && checkCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finalReport

  // hang guard
  always @(posedge sys_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000) begin
      failCount++;
      finalReport();
    end
  end

  // read flags and compare the whole byte
  task automatic chk_flags(input logic [7:0] ex);
    i_cpu.rd(ADDR_FLAGS, b);
    `CHK("flags", ex, b)
  endtask : chk_flags

  // main sequence
  initial begin
    seed = 57;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    i_cpu.rd16(ADDR_COUNT_LOW, v);
    `CHK("count reset", COUNT_RESET, v)
    // stopped counter round trips through the latch
    for (int i = 0; i < 4; i++) begin
      w = 16'($random(seed));
      i_cpu.wr16(ADDR_COUNT_LOW, w);
      i_cpu.rd16(ADDR_COUNT_LOW, v);
      `CHK("count rw", w, v)
    end
    // one high write serves count and compare a
    w = 16'($random(seed));
    i_cpu.wr16(ADDR_COUNT_LOW, w);
    i_cpu.wr(ADDR_CMPA_LOW, ~w[7:0]);
    i_cpu.rd(ADDR_CMPA_HIGH, b);
    `CHK("cmpA high", w[15:8], b)
    i_cpu.wr16(ADDR_CMPB_LOW, ~w);
    i_cpu.rd(ADDR_COUNT_LOW, b);
    i_cpu.rd16(ADDR_CMPB_LOW, v);
    `CHK("cmpB", ~w, v)
    i_cpu.rd(ADDR_COUNT_HIGH, b);
    `CHK("latch kept", w[15:8], b)
    // running counter steps once per cycle
    i_cpu.wr(ADDR_CTRL_B, {5'h00, CSS_DIV1});
    i_cpu.rd16(ADDR_COUNT_LOW, v);
    n = $random(seed) & 31;
    repeat (n) @(posedge sys_clk);
    i_cpu.rd16(ADDR_COUNT_LOW, w);
    `CHK("count step", 16'(v + 16'(n + 6)), w)
    // stopped counter holds
    i_cpu.wr(ADDR_CTRL_B, {5'h00, CSS_STOP});
    i_cpu.rd16(ADDR_COUNT_LOW, v);
    repeat (8) @(posedge sys_clk);
    i_cpu.rd16(ADDR_COUNT_LOW, w);
    `CHK("count stop", v, w)
    // bottom and wrap overflow with interrupt and ack
    i_cpu.wr16(ADDR_COUNT_LOW, COUNT_ZERO);
    @(posedge sys_clk);
    `CHK("bottom", 1'b1, atBottom)
    i_cpu.wr16(ADDR_COUNT_LOW, 16'hfffc);
    i_cpu.wr(ADDR_FLAGS, 8'h03);
    i_cpu.wr(ADDR_MASK, 8'h01);
    i_cpu.wr(ADDR_CTRL_B, {5'h00, CSS_DIV1});
    repeat (8) @(posedge sys_clk);
    i_cpu.wr(ADDR_CTRL_B, {5'h00, CSS_STOP});
    `CHK("ovf irq", 1'b1, overflowIrq)
    overflowAck <= 1'b1;
    @(posedge sys_clk);
    overflowAck <= 1'b0;
    i_cpu.wr(ADDR_MASK, 8'h02);
    chk_flags(8'h00);
    // capture on each polarity with a stopped random count
    for (int p = 0; p < 2; p++) begin
      w = 16'($random(seed));
      captureInputPin <= ~p[0];
      i_cpu.wr16(ADDR_COUNT_LOW, w);
      i_cpu.wr(ADDR_CTRL_B, {1'b0, p[0], 6'h00});
      i_cpu.wr(ADDR_FLAGS, 8'h03);
      captureInputPin <= p[0];
      repeat (4) @(posedge sys_clk);
      `CHK("cap irq", 1'b1, captureIrq)
      chk_flags(8'h02);
      i_cpu.rd16(ADDR_CAPTURE_LOW, v);
      `CHK("capture", w, v)
      i_cpu.wr(ADDR_FLAGS, 8'h00);
      chk_flags(8'h02);
      if (p == 1) begin
        captureAck <= 1'b1;
        @(posedge sys_clk);
        captureAck <= 1'b0;
      end else begin
        i_cpu.wr(ADDR_FLAGS, 8'h02);
      end
      chk_flags(8'h00);
    end
    // filter rejects a three sample glitch and delays by four
    i_cpu.wr(ADDR_CTRL_B, 8'hc0);
    captureInputPin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    i_cpu.wr(ADDR_FLAGS, 8'h03);
    captureInputPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    captureInputPin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk_flags(8'h00);
    captureInputPin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk_flags(8'h00);
    repeat (4) @(posedge sys_clk);
    chk_flags(8'h02);
    // comparator as source, flag cleared after the switch
    i_cpu.wr(ADDR_CTRL_B, 8'h40);
    i_cpu.wr(ADDR_CMP_CTRL, 8'h04);
    i_cpu.wr(ADDR_FLAGS, 8'h02);
    captureInputPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    captureInputPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk_flags(8'h00);
    comparatorOutput <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk_flags(8'h02);
    i_cpu.wr(ADDR_CMP_CTRL, 8'h00);
    i_cpu.wr(ADDR_FLAGS, 8'h02);
    // external pin, one step per rising level change
    i_cpu.wr(ADDR_CTRL_B, {5'h00, CSS_EXT_RISE});
    i_cpu.rd16(ADDR_COUNT_LOW, v);
    n = ($random(seed) & 7) + 1;
    repeat (n) begin
      externalCountPin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      externalCountPin <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
    i_cpu.rd16(ADDR_COUNT_LOW, w);
    `CHK("ext count", 16'(v + 16'(n)), w)
    i_cpu.wr(ADDR_CTRL_B, {5'h00, CSS_STOP});
    // divide by eight from a held prescaler, forty cycles give five steps
    i_cpu.wr16(ADDR_COUNT_LOW, COUNT_ZERO);
    i_cpu.wr(ADDR_CTRL_B, {5'h00, CSS_DIV8});
    repeat (38) @(posedge sys_clk);
    i_cpu.wr(ADDR_CTRL_B, {5'h00, CSS_STOP});
    i_cpu.rd16(ADDR_COUNT_LOW, v);
    `CHK("div8 count", 16'h0005, v)
    // dual slope with eight-bit top turns down at the top
    i_cpu.wr(ADDR_CTRL_A, 8'h01);
    i_cpu.wr16(ADDR_COUNT_LOW, 16'(TOP_8BIT - 16'h0002));
    i_cpu.wr(ADDR_CTRL_B, {5'h00, CSS_DIV1});
    repeat (8) @(posedge sys_clk);
    i_cpu.wr(ADDR_CTRL_B, {5'h00, CSS_STOP});
    i_cpu.rd16(ADDR_COUNT_LOW, v);
    `CHK("dual slope", 16'(TOP_8BIT - 16'h0008), v)
    i_cpu.wr(ADDR_CTRL_A, 8'h00);
    // capture as top: writable, input ignored
    i_cpu.wr(ADDR_CTRL_B, 8'h18);
    @(posedge sys_clk);
    `CHK("mode", 4'hc, waveformModeSelect)
    w = 16'($random(seed));
    i_cpu.wr16(ADDR_CAPTURE_LOW, w);
    i_cpu.rd16(ADDR_CAPTURE_LOW, v);
    `CHK("cap write", w, v)
    i_cpu.wr16(ADDR_COUNT_LOW, w);
    @(posedge sys_clk);
    `CHK("at top", 1'b1, atTop)
    captureInputPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_flags(8'h00);
    i_cpu.wr(ADDR_CTRL_B, 8'h00);
    i_cpu.wr16(ADDR_CAPTURE_LOW, ~w);
    i_cpu.rd16(ADDR_CAPTURE_LOW, v);
    `CHK("cap refused", w, v)
    finalReport();
  end
endmodule : tb_top
`default_nettype wire
